/* File: pov_host_model.sv */
// Management host model that drives the on/off policy, run command, margin and trim.
`timescale 1ns/10ps
module pov_host_model
	import pov_pkg::*;
(
	input wire logic core_clk,
	output pov_policy_type onOffPolicy,
	output logic runCommand,
	output pov_margin_type marginSelect,
	output pov_ref_cfg_type refConfig
);
	initial begin
		onOffPolicy = POV_PIN_ONLY;
		runCommand = 1'b0;
		marginSelect = POV_NO_MARGIN;
		refConfig = '0;
	end
	// Settings change after a falling edge so the block never samples them mid-change.
	task automatic issue(input pov_policy_type p, input logic r, input pov_margin_type m,
		input pov_ref_cfg_type c);
		@(negedge core_clk);
		onOffPolicy = p;
		runCommand = r;
		marginSelect = m;
		refConfig = c;
	endtask
endmodule // pov_host_model

/* File: pov_onoff_ref.sv */
// On/off policy, strapped address and feedback reference computation.
`timescale 1ns/10ps
// Summary of operation
// - Pin-only policy: regulation follows the enable pin, run command ignored.
// - Command-only policy: regulation follows the run command, pin ignored.
// - Combined policy: regulate only while pin and run command both request it.
// - Enable pin polarity is selectable, active high or active low.
// - Address is two octal strap digits, high strap upper, giving 0 to 63.
// - Any out-of-range strap makes the device answer only at address 127.
// - Serial interface works at 100 kHz or 400 kHz bus clock.
// - Numeric arguments use linear format, mantissa times two to the exponent.
// - Trim offset is in 2 mV steps, accepted from -20% to +10%.
// - Margin select chooses no margin, margin high or margin low.
// - Reference is 0.6 V plus trim, plus margin step when margining.
// - Trim plus margin is clamped to -30% to +10% around 600 mV.
// - Second feedback tied to bias rail gives two-phase on first error voltage.
// - Two-phase mode watches faults on first feedback only; both channels react.
// - Output voltage values use linear exponent -9, shown by a format indicator.
module pov_onoff_ref
	import pov_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic channel_enable_pin,
	input wire logic second_channel_enable_pin,
	input wire pov_strap_type low_address_strap,
	input wire pov_strap_type high_address_strap,
	input wire logic second_feedback_input,
	input wire logic first_fault,
	input wire logic second_fault,
	input wire pov_policy_type onOffPolicy,
	input wire logic pinActiveLow,
	input wire logic runCommand,
	input wire pov_margin_type marginSelect,
	input wire pov_ref_cfg_type refConfig,
	output logic [1:0] channelRun,
	output logic [6:0] busAddress,
	output logic signed [15:0] refSteps,
	output logic trimAccepted,
	output logic twoPhase,
	output logic second_error_voltage,
	output logic [1:0] channelFault,
	output logic [7:0] output_format_indicator
);
	logic [1:0] pinMeta;
	logic [1:0] pinSync;
	logic [7:0] strapMeta;
	logic [7:0] strapSync;
	logic bpMeta;
	logic bpSync;
	logic signed [15:0] trimHeld;
	logic [1:0] next_run;
	logic signed [15:0] next_offset;

	// A serial engine sampling the bus on this clock needs headroom even at the fast rate.
	localparam int CORE_CLK_HZ = 250000000;
	if (CORE_CLK_HZ < 8 * BUS_400K_HZ) begin : gen_rate_check
		$error("core clock too slow for the serial bus rates");
	end

	// Pins and straps come from outside the clock domain.
	always_ff @(posedge core_clk) begin
		pinMeta <= {second_channel_enable_pin, channel_enable_pin};
		pinSync <= pinMeta;
		strapMeta <= {high_address_strap, low_address_strap};
		strapSync <= strapMeta;
		bpMeta <= second_feedback_input;
		bpSync <= bpMeta;
	end

	always_comb begin
		logic [1:0] pinReq;
		logic [1:0] pinUse;
		pinReq = pinSync ^ {2{pinActiveLow}};
		// The second pin is unused in two-phase mode; channel one drives both phases.
		pinUse = twoPhase ? {2{pinReq[0]}} : pinReq;
		case (onOffPolicy)
			POV_PIN_ONLY: next_run = pinUse;
			POV_CMD_ONLY: next_run = {2{runCommand}};
			POV_BOTH: next_run = pinUse & {2{runCommand}};
			default: next_run = 2'h3;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			channelRun <= 2'h0;
		end else begin
			channelRun <= next_run;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			busAddress <= FALLBACK_ADDR;
		end else if (strapSync[0] && strapSync[4]) begin
			busAddress <= {1'b0, strapSync[7:5], strapSync[3:1]};
		end else begin
			busAddress <= FALLBACK_ADDR;
		end
	end

	// Out-of-range trim writes are refused and the last accepted value is kept.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			trimHeld <= 16'sd0;
			trimAccepted <= 1'b0;
		end else if (refConfig.trim >= TRIM_MIN_STEPS && refConfig.trim <= TRIM_MAX_STEPS) begin
			trimHeld <= refConfig.trim;
			trimAccepted <= 1'b1;
		end else begin
			trimAccepted <= 1'b0;
		end
	end

	// One extra bit keeps a large margin step from wrapping before the clamp sees it.
	always_comb begin
		logic signed [16:0] sum;
		sum = 17'(trimHeld);
		case (marginSelect)
			POV_MARGIN_HIGH: sum = 17'(trimHeld) + 17'(refConfig.marginHigh);
			POV_MARGIN_LOW: sum = 17'(trimHeld) + 17'(refConfig.marginLow);
			default: sum = 17'(trimHeld);
		endcase
		if (sum < 17'(TOTAL_MIN_STEPS)) begin
			next_offset = TOTAL_MIN_STEPS;
		end else if (sum > 17'(TOTAL_MAX_STEPS)) begin
			next_offset = TOTAL_MAX_STEPS;
		end else begin
			next_offset = 16'(sum);
		end
	end

	// Reference is reported in 2 mV units, so 300 means 600 mV.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			refSteps <= NOMINAL_STEPS;
		end else begin
			refSteps <= 16'(NOMINAL_STEPS + next_offset);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			twoPhase <= 1'b0;
			second_error_voltage <= 1'b0;
			channelFault <= 2'h0;
			output_format_indicator <= 8'h00;
		end else begin
			twoPhase <= bpSync;
			second_error_voltage <= bpSync;
			channelFault <= bpSync ? {2{first_fault}} : {second_fault, first_fault};
			output_format_indicator <= OUTPUT_FORMAT_CODE;
		end
	end

	// Every result is registered, so each triggered check looks one edge after its cause; the range checks hold on every edge.
	chk_cmd_only_run: assert property (@(posedge core_clk) disable iff (reset)
		onOffPolicy == POV_CMD_ONLY |=> channelRun == {2{$past(runCommand)}})
		else $error("command-only run mismatch");
	chk_pin_only_run: assert property (@(posedge core_clk) disable iff (reset)
		onOffPolicy == POV_PIN_ONLY && !twoPhase
		|=> channelRun[0] == ($past(pinSync[0]) ^ $past(pinActiveLow)))
		else $error("pin-only run mismatch");
	chk_pin2_only: assert property (@(posedge core_clk) disable iff (reset)
		onOffPolicy == POV_PIN_ONLY && !twoPhase
		|=> channelRun[1] == ($past(pinSync[1]) ^ $past(pinActiveLow)))
		else $error("second channel pin-only run mismatch");
	chk_twophase_pins: assert property (@(posedge core_clk) disable iff (reset)
		onOffPolicy == POV_PIN_ONLY && twoPhase
		|=> channelRun == {2{$past(pinSync[0]) ^ $past(pinActiveLow)}})
		else $error("two-phase run does not follow first pin");
	chk_both_needed: assert property (@(posedge core_clk) disable iff (reset)
		onOffPolicy == POV_BOTH && !runCommand |=> channelRun == 2'h0)
		else $error("combined policy ran without command");
	chk_both_run: assert property (@(posedge core_clk) disable iff (reset)
		onOffPolicy == POV_BOTH && runCommand && !twoPhase
		|=> channelRun == ($past(pinSync) ^ {2{$past(pinActiveLow)}}))
		else $error("combined policy ignored pin");
	chk_fallback_addr: assert property (@(posedge core_clk) disable iff (reset)
		!strapSync[0] |=> busAddress == 7'h7f)
		else $error("bad strap did not give fallback address");
	chk_high_fallback: assert property (@(posedge core_clk) disable iff (reset)
		!strapSync[4] |=> busAddress == 7'h7f)
		else $error("bad high strap did not give fallback address");
	chk_strap_addr: assert property (@(posedge core_clk) disable iff (reset)
		strapSync[0] && strapSync[4]
		|=> busAddress == {1'b0, $past(strapSync[7:5]), $past(strapSync[3:1])})
		else $error("strapped address wrong");
	chk_addr_range: assert property (@(posedge core_clk) disable iff (reset)
		busAddress <= 7'h3f || busAddress == 7'h7f)
		else $error("address outside strapped range");
	chk_ref_band: assert property (@(posedge core_clk) disable iff (reset)
		refSteps >= 16'sd210 && refSteps <= 16'sd330)
		else $error("reference outside band");
	chk_clamp_high: assert property (@(posedge core_clk) disable iff (reset)
		marginSelect == POV_MARGIN_HIGH && refConfig.marginHigh > 16'sh0078
		|=> refSteps == 16'sh014a)
		else $error("large high margin not clamped");
	chk_clamp_low: assert property (@(posedge core_clk) disable iff (reset)
		marginSelect == POV_MARGIN_LOW && refConfig.marginLow < -16'sh0078
		|=> refSteps == 16'sh00d2)
		else $error("large low margin not clamped");
	chk_nomargin_ref: assert property (@(posedge core_clk) disable iff (reset)
		marginSelect == POV_NO_MARGIN ##1 marginSelect == POV_NO_MARGIN
		|=> refSteps == 16'($past(trimHeld) + 16'sd300))
		else $error("no-margin reference wrong");
	chk_rsvd_margin_ref: assert property (@(posedge core_clk) disable iff (reset)
		marginSelect == POV_MARGIN_RSVD ##1 marginSelect == POV_MARGIN_RSVD
		|=> refSteps == 16'($past(trimHeld) + 16'sd300))
		else $error("unused margin code not treated as no margin");
	chk_trim_range: assert property (@(posedge core_clk) disable iff (reset)
		trimHeld >= -16'sd60 && trimHeld <= 16'sd30)
		else $error("held trim out of range");
	chk_trim_taken: assert property (@(posedge core_clk) disable iff (reset)
		refConfig.trim >= TRIM_MIN_STEPS && refConfig.trim <= TRIM_MAX_STEPS
		|=> trimAccepted && trimHeld == $past(refConfig.trim))
		else $error("in-range trim not taken");
	chk_trim_refused: assert property (@(posedge core_clk) disable iff (reset)
		refConfig.trim < TRIM_MIN_STEPS || refConfig.trim > TRIM_MAX_STEPS
		|=> !trimAccepted && $stable(trimHeld))
		else $error("out-of-range trim not refused");
	chk_twophase_flags: assert property (@(posedge core_clk) disable iff (reset)
		bpSync |=> twoPhase && second_error_voltage)
		else $error("two-phase mode not indicated");
	chk_twophase_fault: assert property (@(posedge core_clk) disable iff (reset)
		bpSync |=> channelFault == {2{$past(first_fault)}})
		else $error("two-phase fault not shared");
	chk_fault_split: assert property (@(posedge core_clk) disable iff (reset)
		!bpSync |=> channelFault == {$past(second_fault), $past(first_fault)})
		else $error("dual-channel faults not independent");
	chk_format_code: assert property (@(posedge core_clk) disable iff (reset)
		$past(reset) == 1'b0 |-> output_format_indicator == 8'h17)
		else $error("format indicator wrong");
endmodule // pov_onoff_ref

/* File: pov_onoff_ref_tb.sv */
// Self-checking testbench for the on/off, address and reference block.
`timescale 1ns/10ps
module pov_onoff_ref_tb;
	import pov_pkg::*;
	logic core_clk = 1'b0, reset = 1'b1, pinLevel = 1'b0, pinActiveLow = 1'b0;
	logic feedbackTied = 1'b0, fault1 = 1'b0, fault2 = 1'b0;
	logic pin2Level = 1'b0;
	pov_strap_type lowStrap = '0, highStrap = '0;
	pov_policy_type onOffPolicy;
	logic runCommand;
	pov_margin_type marginSelect;
	pov_ref_cfg_type refConfig;
	logic [1:0] channelRun, channelFault;
	logic [6:0] busAddress;
	logic signed [15:0] refSteps;
	logic trimAccepted, twoPhase, sharedErr;
	logic [7:0] formatCode;
	int n_errors = 0, checks_done = 0;
	pov_host_model pov_host_model_inst(.core_clk(core_clk), .onOffPolicy(onOffPolicy),
		.runCommand(runCommand), .marginSelect(marginSelect), .refConfig(refConfig));
	pov_onoff_ref pov_onoff_ref_inst(.core_clk(core_clk), .reset(reset),
		.channel_enable_pin(pinLevel), .second_channel_enable_pin(pin2Level),
		.low_address_strap(lowStrap), .high_address_strap(highStrap),
		.second_feedback_input(feedbackTied), .first_fault(fault1), .second_fault(fault2),
		.onOffPolicy(onOffPolicy), .pinActiveLow(pinActiveLow), .runCommand(runCommand),
		.marginSelect(marginSelect), .refConfig(refConfig), .channelRun(channelRun),
		.busAddress(busAddress), .refSteps(refSteps), .trimAccepted(trimAccepted),
		.twoPhase(twoPhase), .second_error_voltage(sharedErr), .channelFault(channelFault),
		.output_format_indicator(formatCode));
	initial forever #2 core_clk = ~core_clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Pins pass a two-stage synchroniser, so four edges cover the worst latency.
	task automatic settle();
		repeat (4) @(negedge core_clk);
	endtask
	task automatic test_policy();
		logic act, exp;
		for (int k = 0; k < 32; k++) begin
			act = k[1] ^ k[2];
			exp = (k[4:3] == 0) ? act : (k[4:3] == 1) ? k[0] : (k[4:3] == 2) ? act & k[0] : 1'b1;
			pov_host_model_inst.issue(pov_policy_type'(k[4:3]), k[0], POV_NO_MARGIN, '0);
			pinLevel = k[1];
			pin2Level = k[1];
			pinActiveLow = k[2];
			settle();
			chk(16'(channelRun), {14'h0, exp, exp});
		end
		$display("test_policy done");
	endtask
	task automatic test_address();
		for (int k = 0; k < 64; k++) begin
			highStrap = '{k[5:3], 1'b1};
			lowStrap = '{k[2:0], 1'b1};
			settle();
			chk(16'(busAddress), 16'(k));
		end
		lowStrap.valid = 1'b0;
		settle();
		chk(16'(busAddress), 16'h007f);
		lowStrap.valid = 1'b1;
		highStrap.valid = 1'b0;
		settle();
		chk(16'(busAddress), 16'h007f);
		$display("test_address done");
	endtask
	task automatic refCase(input int t, input int h, input int l, input pov_margin_type m,
		input int expRef, input logic expAcc);
		pov_host_model_inst.issue(POV_CMD_ONLY, 1'b1, m, pov_ref_cfg_type'{16'(t), 16'(h), 16'(l)});
		repeat (3) @(negedge core_clk);
		chk(refSteps, 16'(expRef));
		chk(16'(trimAccepted), 16'(expAcc));
	endtask
	task automatic test_reference();
		refCase(10, 0, 0, POV_NO_MARGIN, 310, 1'b1);
		refCase(10, 20, 0, POV_MARGIN_HIGH, 330, 1'b1);
		refCase(10, 0, -40, POV_MARGIN_LOW, 270, 1'b1);
		refCase(-60, 0, -40, POV_MARGIN_LOW, 210, 1'b1);
		refCase(30, 30, 0, POV_MARGIN_HIGH, 330, 1'b1);
		refCase(-61, 0, 0, POV_NO_MARGIN, 330, 1'b0);
		refCase(30, 32767, 0, POV_MARGIN_HIGH, 330, 1'b1);
		refCase(31, 0, -200, POV_MARGIN_LOW, 210, 1'b0);
		refCase(0, 20, -20, POV_MARGIN_RSVD, 300, 1'b1);
		$display("test_reference done");
	endtask
	task automatic test_two_phase();
		pov_host_model_inst.issue(POV_PIN_ONLY, 1'b0, POV_NO_MARGIN, '0);
		pinActiveLow = 1'b0;
		pinLevel = 1'b1;
		pin2Level = 1'b0;
		fault2 = 1'b1;
		settle();
		chk(16'(channelRun), 16'h0001);
		chk(16'(channelFault), 16'h0002);
		chk({14'h0, twoPhase, sharedErr}, 16'h0000);
		feedbackTied = 1'b1;
		fault1 = 1'b1;
		fault2 = 1'b0;
		settle();
		chk({14'h0, twoPhase, sharedErr}, 16'h0003);
		chk(16'(channelFault), 16'h0003);
		chk(16'(channelRun), 16'h0003);
		fault1 = 1'b0;
		fault2 = 1'b1;
		settle();
		chk(16'(channelFault), 16'h0000);
		chk(16'(formatCode), 16'h0017);
		$display("test_two_phase done");
	endtask
	task automatic test_reset();
		reset = 1'b1;
		repeat (2) @(negedge core_clk);
		chk(16'(channelRun), 16'h0000);
		chk(16'(busAddress), 16'h007f);
		chk(refSteps, 16'h012c);
		chk({13'h0, trimAccepted, twoPhase, sharedErr}, 16'h0000);
		chk(16'(formatCode), 16'h0000);
		reset = 1'b0;
		settle();
		chk(16'(formatCode), 16'h0017);
		chk(refSteps, 16'h012c);
		chk(16'(trimAccepted), 16'h0001);
		chk(16'(channelRun), 16'h0003);
		$display("test_reset done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge core_clk);
		reset = 1'b0;
		test_policy();
		test_address();
		test_reference();
		test_two_phase();
		test_reset();
		complete_run();
	end
	initial begin
		#4000;
		n_errors++;
		complete_run();
	end
endmodule // pov_onoff_ref_tb

/* File: pov_pkg.sv */
// Package with constants and carrier types for the on/off, address and reference block.
package pov_pkg;
	localparam int ADDR_DIGIT_W = 3;
	localparam int ADDR_W = 7;
	localparam logic [6:0] FALLBACK_ADDR = 7'h7f;
	localparam logic [2:0] OCTAL_MAX = 3'h7;
	localparam int CODE_W = 16;
	// Reference and offsets are in 2 mV steps, signed, linear with exponent -9 style.
	localparam int VOUT_EXP = -9;
	localparam logic [7:0] OUTPUT_FORMAT_CODE = 8'h17;
	localparam int STEP_MV = 2;
	localparam int NOMINAL_MV = 600;
	localparam logic signed [15:0] NOMINAL_STEPS = 16'sd300;
	localparam logic signed [15:0] TRIM_MIN_STEPS = -16'sd60;
	localparam logic signed [15:0] TRIM_MAX_STEPS = 16'sd30;
	localparam logic signed [15:0] TOTAL_MIN_STEPS = -16'sd90;
	localparam logic signed [15:0] TOTAL_MAX_STEPS = 16'sd30;
	localparam logic [1:0] RESET_MARGIN = 2'h0;
	localparam int BUS_100K_HZ = 100000;
	localparam int BUS_400K_HZ = 400000;

	typedef enum logic [1:0] {
		POV_PIN_ONLY,
		POV_CMD_ONLY,
		POV_BOTH,
		POV_ALWAYS
	} pov_policy_type;

	typedef enum logic [1:0] {
		POV_NO_MARGIN,
		POV_MARGIN_HIGH,
		POV_MARGIN_LOW,
		POV_MARGIN_RSVD
	} pov_margin_type;

	typedef struct packed {
		logic [2:0] digit;
		logic valid;
	} pov_strap_type;

	typedef struct packed {
		logic signed [15:0] trim;
		logic signed [15:0] marginHigh;
		logic signed [15:0] marginLow;
	} pov_ref_cfg_type;
endpackage
